/* event_channel_router.sv */
// four-channel event router with filters, quadrature decode and manual events
//
// Design decision made here: the strobed register port.
`timescale 1ns/1ps

module event_channel_router (
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic        ce,
  input  wire logic [7:0]  addr,
  input  wire logic [7:0]  write_data,
  input  wire logic        write_en,
  input  wire logic        read_en,
  output logic      [7:0]  read_data,
  input  wire logic [47:0] port_pin_event_source,
  input  wire logic [4:0]  timer_wrap_event,
  input  wire logic [4:0]  timer_fault_event,
  input  wire logic [4:0]  timer_match_a_event,
  input  wire logic [4:0]  timer_match_b_event,
  input  wire logic [4:0]  timer_match_c_event,
  input  wire logic [4:0]  timer_match_d_event,
  output logic      [3:0]  channel_event,
  output logic      [3:0]  channel_data,
  output logic      [1:0]  quad_step_up,
  output logic      [1:0]  quad_step_down,
  output logic      [1:0]  quad_index_event
);

  // ---------------------------------------------
  // source decoding
  // ---------------------------------------------
  function automatic logic route_source(
    input logic [7:0]                  code,
    input logic [47:0]                 pins,
    input logic [15:0]                 ticks,
    input event_router_pkg::timer_bank_t tev
  );
    logic [3:0] nib;
    logic [7:0] off;
    logic [2:0] tsel;
    logic       tok;
    nib  = code[7:4];
    off  = code - event_router_pkg::PIN_BASE;
    tsel = 3'h0;
    tok  = 1'b0;
    case (nib)
      event_router_pkg::NIB_TC_AB:
      begin
        tsel = {2'b00, code[3]};
        tok  = 1'b1;
      end
      event_router_pkg::NIB_TC_D:
      begin
        tsel = 3'h2;
        tok  = !code[3];
      end
      event_router_pkg::NIB_TC_E:
      begin
        tsel = 3'h3;
        tok  = !code[3];
      end
      event_router_pkg::NIB_TC_F:
      begin
        tsel = 3'h4;
        tok  = !code[3];
      end
      default:
      begin
        tsel = 3'h0;
        tok  = 1'b0;
      end
    endcase
    if (code[2:1] == 2'b01)
      tok = 1'b0;
    if (code[2:1] == 2'b11 && tsel == 3'h1)
      tok = 1'b0;
    route_source = 1'b0;
    if (nib >= event_router_pkg::NIB_PIN_LO && nib <= event_router_pkg::NIB_PIN_HI)
      route_source = pins[off[5:0]];
    else if (nib == event_router_pkg::NIB_PRESC)
      route_source = ticks[code[3:0]];
    else if (tok)
      route_source = tev[tsel][code[2:0]];
  endfunction

  // forward step when b leads a
  function automatic logic quad_forward(
    input logic [1:0] from_state,
    input logic [1:0] to_state
  );
    quad_forward = (from_state == 2'b00 && to_state == 2'b01) ||
                   (from_state == 2'b01 && to_state == 2'b11) ||
                   (from_state == 2'b11 && to_state == 2'b10) ||
                   (from_state == 2'b10 && to_state == 2'b00);
  endfunction

  // ---------------------------------------------
  // registers and state
  // ---------------------------------------------
  logic [3:0][7:0]               channel_source_select;
  logic [3:0][7:0]               channel_control;
  logic [7:0]                    manual_event_trigger;
  logic [7:0]                    manual_event_value;
  logic [event_router_pkg::PRESC_W-1:0] presc_cnt;
  logic [1:0][1:0]               phase_prev;

  event_router_pkg::timer_bank_t tev;
  logic [15:0]                   ticks;
  logic [3:0]                    raw_src;
  logic [1:0]                    raw_phase_b;
  logic [7:0]                    read_mux;
  logic                          trig_hit;
  logic [3:0]                    inject;
  logic [1:0][1:0]               phase_state;
  logic [1:0]                    step_fwd;
  logic [1:0]                    step_rev;
  logic [1:0]                    index_hit;

  filter_lanes_if #(.LANES(event_router_pkg::NUM_LANES)) lanes ();

  event_input_filter #(
    .LANES (event_router_pkg::NUM_LANES)
  ) u_filter (
    .core_clk (core_clk),
    .rst      (rst),
    .ce       (ce),
    .lanes    (lanes.filter)
  );

  // ---------------------------------------------
  // source selection
  // ---------------------------------------------
  for (genvar t = 0; t < event_router_pkg::NUM_TIMERS; t++)
  begin : g_tev
    assign tev[t] = {timer_match_d_event[t], timer_match_c_event[t],
                     timer_match_b_event[t], timer_match_a_event[t],
                     2'b00, timer_fault_event[t], timer_wrap_event[t]};
  end

  for (genvar m = 0; m < event_router_pkg::PRESC_W; m++)
  begin : g_tick
    if (m == 0)
    begin : g_full
      assign ticks[m] = 1'b1;
    end
    else
    begin : g_div
      assign ticks[m] = ~|presc_cnt[m-1:0];
    end
  end

  for (genvar c = 0; c < event_router_pkg::NUM_CH; c++)
  begin : g_ch
    assign raw_src[c] = route_source(channel_source_select[c],
                                     port_pin_event_source, ticks, tev);
    assign lanes.sample[c] = raw_src[c];
    assign lanes.len[c]    = channel_control[c][event_router_pkg::FILT_LSB +: 3];
  end

  // ---------------------------------------------
  // quadrature decoders on channels 0 and 2
  // ---------------------------------------------
  for (genvar d = 0; d < 2; d++)
  begin : g_quad
    assign raw_phase_b[d] = route_source({channel_source_select[2*d][7:3],
                                          channel_source_select[2*d][2:0] + 3'h1},
                                         port_pin_event_source, ticks, tev);
    assign lanes.sample[4+d] = raw_phase_b[d];
    assign lanes.len[4+d]    = channel_control[2*d][event_router_pkg::FILT_LSB +: 3];
    assign phase_state[d]    = {lanes.level[2*d], lanes.level[4+d]};
    assign step_fwd[d] = channel_control[2*d][event_router_pkg::QUAD_DECODE_ENABLE_BIT] &&
                         quad_forward(phase_prev[d], phase_state[d]);
    assign step_rev[d] = channel_control[2*d][event_router_pkg::QUAD_DECODE_ENABLE_BIT] &&
                         quad_forward(phase_state[d], phase_prev[d]);
    assign index_hit[d] = channel_control[2*d][event_router_pkg::INDEX_SOURCE_ENABLE_BIT] &&
                          lanes.level[2*d+1] &&
                          phase_state[d] == channel_control[2*d][event_router_pkg::IRM_LSB +: 2];
  end

  // ---------------------------------------------
  // register access decode
  // ---------------------------------------------
  assign trig_hit = ce && write_en && addr == event_router_pkg::OFF_TRIG;
  assign inject   = trig_hit ? (write_data[3:0] | manual_event_value[3:0]) : 4'h0;

  always_comb
  begin
    read_mux = 8'h00;
    for (int c = 0; c < event_router_pkg::NUM_CH; c++)
    begin
      if (addr == event_router_pkg::OFF_MUX0 + 8'(c))
        read_mux = channel_source_select[c];
      if (addr == event_router_pkg::OFF_CTRL0 + 8'(c))
        read_mux = channel_control[c];
    end
    if (addr == event_router_pkg::OFF_TRIG)
      read_mux = manual_event_trigger;
    if (addr == event_router_pkg::OFF_VALUE)
      read_mux = manual_event_value;
  end

  // ---------------------------------------------
  // register writes
  // ---------------------------------------------
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      channel_source_select <= '0;
      channel_control       <= '0;
      manual_event_trigger  <= event_router_pkg::RST_BYTE;
      manual_event_value    <= event_router_pkg::RST_BYTE;
    end
    else if (ce && write_en)
    begin
      for (int c = 0; c < event_router_pkg::NUM_CH; c++)
      begin
        if (addr == event_router_pkg::OFF_MUX0 + 8'(c))
          channel_source_select[c] <= write_data;
        if (addr == event_router_pkg::OFF_CTRL0 + 8'(c))
          channel_control[c] <= write_data & ((c % 2 == 0) ? event_router_pkg::CTRL_MASK_QUAD :
                                              event_router_pkg::CTRL_MASK_PLAIN);
      end
      if (addr == event_router_pkg::OFF_TRIG)
        manual_event_trigger <= write_data;
      if (addr == event_router_pkg::OFF_VALUE)
        manual_event_value <= write_data;
    end
  end

  // ---------------------------------------------
  // read data, prescaler, outputs
  // ---------------------------------------------
  always_ff @(posedge core_clk)
  begin
    if (rst)
      read_data <= 8'h00;
    else if (ce && read_en)
      read_data <= read_mux;
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
      presc_cnt <= '0;
    else if (ce)
      presc_cnt <= presc_cnt + 16'h0001;
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      channel_event    <= 4'h0;
      channel_data     <= 4'h0;
      phase_prev       <= '0;
      quad_step_up     <= 2'b00;
      quad_step_down   <= 2'b00;
      quad_index_event <= 2'b00;
    end
    else if (ce)
    begin
      channel_event    <= lanes.level[3:0] | inject;
      channel_data     <= (inject & manual_event_value[3:0]) | (~inject & lanes.level[3:0]);
      phase_prev       <= phase_state;
      quad_step_up     <= step_fwd;
      quad_step_down   <= step_rev;
      quad_index_event <= index_hit;
    end
  end

  // ---------------------------------------------
  // checks
  // ---------------------------------------------
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);

  sequence s_trig_write;
    ce && write_en && addr == event_router_pkg::OFF_TRIG && (write_data[3:0] | manual_event_value[3:0]) != 4'h0;
  endsequence

  sequence s_quiet_cycle;
    ce && !trig_hit && lanes.level[3:0] == 4'h0;
  endsequence

  trig_inject_a : assert property (s_trig_write |=> channel_event == ($past(write_data[3:0] | manual_event_value[3:0])
                                   | $past(lanes.level[3:0])))
    else $error("trigger write did not inject on selected channels");

  inject_once_a : assert property (s_trig_write ##1 s_quiet_cycle |=> channel_event == 4'h0)
    else $error("injected event lasted more than one cycle");

  zero_code_a : assert property (channel_source_select[0] == 8'h00 |-> raw_src[0] == 1'b0)
    else $error("code zero routed a source");

  reserved_code_a : assert property (channel_source_select[1][7:4] == 4'h9 |-> raw_src[1] == 1'b0)
    else $error("reserved code routed a source");

  presc_full_a : assert property (channel_source_select[2] == 8'h80 |-> raw_src[2] == 1'b1)
    else $error("undivided clock source not high");

  pin_select_a : assert property (channel_source_select[3] == 8'h5b |-> raw_src[3] == port_pin_event_source[11])
    else $error("pin code picked wrong pin");

  ctrl_read_a : assert property ((ce && read_en && addr == event_router_pkg::OFF_CTRL0 + 8'h01) |=>
                                 read_data[7:3] == 5'h00)
    else $error("reserved control bits read non-zero");

  value_read_a : assert property ((ce && read_en && addr == event_router_pkg::OFF_VALUE) |=>
                                  read_data == $past(manual_event_value))
    else $error("value register read mismatch");

  quad_fwd_a : assert property ((ce && channel_control[0][event_router_pkg::QUAD_DECODE_ENABLE_BIT]
                                 && phase_prev[0] == 2'b00 && phase_state[0] == 2'b01) |=> quad_step_up[0])
    else $error("forward phase step not reported");

  quad_off_a : assert property ((ce && !channel_control[2][event_router_pkg::QUAD_DECODE_ENABLE_BIT]) |=>
                                !quad_step_up[1] && !quad_step_down[1])
    else $error("decoder stepped while disabled");

  index_gate_a : assert property ((ce && !channel_control[0][event_router_pkg::INDEX_SOURCE_ENABLE_BIT]) |=> !quad_index_event[0])
    else $error("index event without index enable");

  index_state_a : assert property (quad_index_event[0] |-> $past(phase_state[0]) ==
                                   $past(channel_control[0][event_router_pkg::IRM_LSB +: 2]))
    else $error("index event at wrong phase state");

endmodule

/* event_input_filter.sv */
// per-lane sample filter: passes a level after len+1 equal samples
`timescale 1ns/1ps
module event_input_filter #(
  parameter int LANES = 6
) (
  input wire logic          core_clk,
  input wire logic          rst,
  input wire logic          ce,
  filter_lanes_if.filter    lanes
);

  logic [LANES-1:0]      prev;
  logic [LANES-1:0][2:0] run;
  logic [LANES-1:0][2:0] next_run;

  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);

  // ---------------------------------------------
  // run length state of all lanes, one process
  // ---------------------------------------------
  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      prev        <= '0;
      run         <= '0;
      lanes.level <= '0;
    end
    else if (ce)
    begin
      prev <= lanes.sample;
      run  <= next_run;
      for (int i = 0; i < LANES; i++)
      begin
        if (next_run[i] >= lanes.len[i])
          lanes.level[i] <= lanes.sample[i];
      end
    end
  end

  for (genvar i = 0; i < LANES; i++)
  begin : g_lane
    // ---------------------------------------------
    // run length of equal samples
    // ---------------------------------------------
    assign next_run[i] = (lanes.sample[i] != prev[i]) ? 3'h0 :
                         (run[i] == 3'h7) ? run[i] : run[i] + 3'h1;

    // ---------------------------------------------
    // checks
    // ---------------------------------------------
    filter_hold_a : assert property ((ce && next_run[i] < lanes.len[i]) |=> $stable(lanes.level[i]))
      else $error("filter level moved before run length reached");
    filter_pass_a : assert property ((ce && lanes.len[i] == 3'h0) |=> lanes.level[i] == $past(lanes.sample[i]))
      else $error("single-sample filter did not follow input");
  end

endmodule

/* event_peripheral_model.sv */
// far-side peripherals: port pins and timer event levels feeding the router
`timescale 1ns/1ps
module event_peripheral_model (
  input  wire logic        core_clk,
  output logic      [47:0] pins,
  output logic      [4:0]  wrap_ev,
  output logic      [4:0]  fault_ev,
  output logic      [4:0]  match_a_ev,
  output logic      [4:0]  match_b_ev,
  output logic      [4:0]  match_c_ev,
  output logic      [4:0]  match_d_ev
);
  // ---------------------------------------------------------------
  // producers change levels only right after a clock edge
  // ---------------------------------------------------------------
  initial
  begin
    pins = '0;
    {wrap_ev, fault_ev, match_a_ev, match_b_ev, match_c_ev, match_d_ev} = '0;
  end

  task automatic set_pin(input int idx, input logic lvl);
    @(posedge core_clk);
    pins[idx] <= lvl;
  endtask

  // c/d of the second timer are driven too; the router must ignore them
  task automatic set_timers(input logic [4:0] v);
    @(posedge core_clk);
    {wrap_ev, fault_ev, match_a_ev, match_b_ev, match_c_ev, match_d_ev} <= {6{v}};
  endtask
endmodule

/* event_router_pkg.sv */
// shared constants and types of the event channel router
package event_router_pkg;

  // register offsets and reset value
  localparam logic [7:0] OFF_MUX0  = 8'h00;
  localparam logic [7:0] OFF_CTRL0 = 8'h08;
  localparam logic [7:0] OFF_TRIG  = 8'h10;
  localparam logic [7:0] OFF_VALUE = 8'h11;
  localparam logic [7:0] RST_BYTE  = 8'h00;

  // control register fields
  localparam int FILT_LSB  = 0;
  localparam int QUAD_DECODE_ENABLE_BIT  = 3;
  localparam int INDEX_SOURCE_ENABLE_BIT = 4;
  localparam int IRM_LSB   = 5;
  localparam int RSVD_BIT  = 7;
  localparam logic [7:0] CTRL_MASK_QUAD  = 8'h7f;
  localparam logic [7:0] CTRL_MASK_PLAIN = 8'h07;

  // source code nibbles and pin code base
  localparam logic [3:0] NIB_PIN_LO = 4'h5;
  localparam logic [3:0] NIB_PIN_HI = 4'h7;
  localparam logic [3:0] NIB_PRESC  = 4'h8;
  localparam logic [3:0] NIB_TC_AB  = 4'hc;
  localparam logic [3:0] NIB_TC_D   = 4'hd;
  localparam logic [3:0] NIB_TC_E   = 4'he;
  localparam logic [3:0] NIB_TC_F   = 4'hf;
  localparam logic [7:0] PIN_BASE   = 8'h50;

  // sizes
  localparam int NUM_CH     = 4;
  localparam int NUM_TIMERS = 5;
  localparam int NUM_PINS   = 48;
  localparam int PRESC_W    = 16;
  localparam int NUM_LANES  = 6;

  typedef logic [NUM_TIMERS-1:0][7:0] timer_bank_t;

endpackage

/* filter_lanes_if.sv */
// carrier between the router and its input filters
`timescale 1ns/1ps
interface filter_lanes_if #(parameter int LANES = 6);
  logic [LANES-1:0]      sample;
  logic [LANES-1:0][2:0] len;
  logic [LANES-1:0]      level;

  modport router (output sample, output len, input level);
  modport filter (input sample, input len, output level);
endinterface

/* testbench.sv */
// self-checking testbench of the event channel router
`timescale 1ns/1ps
module testbench;
  logic        core_clk = 1'b0;
  logic        rst      = 1'b1;
  logic        ce       = 1'b1;
  logic [7:0]  addr     = 8'h00;
  logic [7:0]  write_data = 8'h00;
  logic        write_en = 1'b0;
  logic        read_en  = 1'b0;
  logic [7:0]  read_data;
  logic [47:0] pins;
  logic [4:0]  wr_ev, ft_ev, ma_ev, mb_ev, mc_ev, md_ev;
  logic [3:0]  channel_event, channel_data;
  logic [1:0]  quad_step_up, quad_step_down, quad_index_event;
  wire  [9:0]  obs = {quad_index_event, quad_step_down, quad_step_up, channel_event};
  int          fail_count = 0;
  int          n_tests    = 0;
  logic [7:0]  v;
  int          c;
  logic [7:0]  ra [10] = '{8'h10, 8'h11, 8'h08, 8'h09, 8'h0a, 8'h0b, 8'h03, 8'h04, 8'h0c, 8'h12};
  logic [7:0]  rw [10] = '{8'ha5, 8'h3c, 8'hff, 8'hff, 8'hff, 8'hff, 8'hc4, 8'hff, 8'hff, 8'hff};
  logic [7:0]  re [10] = '{8'ha5, 8'h3c, 8'h7f, 8'h07, 8'h7f, 8'h07, 8'hc4, 8'h00, 8'h00, 8'h00};
  logic [7:0]  tc [19] = '{8'hc0, 8'hc1, 8'hc2, 8'hc3, 8'hc4, 8'hc5, 8'hc6, 8'hc7, 8'hc8, 8'hce,
                           8'hcf, 8'hd0, 8'hd8, 8'he4, 8'hf5, 8'hf8, 8'h40, 8'h90, 8'h00};
  logic [18:0] te = 19'b000_0110_1001_1111_0011;

  always #2.5 core_clk = ~core_clk;

  event_peripheral_model event_peripheral_model_inst (
    .core_clk   (core_clk),
    .pins       (pins),
    .wrap_ev    (wr_ev),
    .fault_ev   (ft_ev),
    .match_a_ev (ma_ev),
    .match_b_ev (mb_ev),
    .match_c_ev (mc_ev),
    .match_d_ev (md_ev)
  );

  event_channel_router event_channel_router_inst (
    .core_clk              (core_clk),
    .rst                   (rst),
    .ce                    (ce),
    .addr                  (addr),
    .write_data            (write_data),
    .write_en              (write_en),
    .read_en               (read_en),
    .read_data             (read_data),
    .port_pin_event_source (pins),
    .timer_wrap_event      (wr_ev),
    .timer_fault_event     (ft_ev),
    .timer_match_a_event   (ma_ev),
    .timer_match_b_event   (mb_ev),
    .timer_match_c_event   (mc_ev),
    .timer_match_d_event   (md_ev),
    .channel_event         (channel_event),
    .channel_data          (channel_data),
    .quad_step_up          (quad_step_up),
    .quad_step_down        (quad_step_down),
    .quad_index_event      (quad_index_event)
  );

  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    addr <= a;
    write_data <= d;
    write_en <= 1'b1;
    @(posedge core_clk);
    write_en <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge core_clk);
    addr <= a;
    read_en <= 1'b1;
    @(posedge core_clk);
    read_en <= 1'b0;
    #1;
    d = read_data;
  endtask

  // counts cycles in which observed bit sel is high
  task automatic count(input int n, input int sel, output int k);
    k = 0;
    repeat (n)
    begin
      @(posedge core_clk);
      #1;
      k += int'(obs[sel]);
    end
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic test_regs();
    for (int i = 0; i < 10; i++)
    begin
      rd(ra[i], v);
      check("reset value", v, 8'h00);
    end
    for (int i = 0; i < 10; i++)
    begin
      wr(ra[i], rw[i]);
      rd(ra[i], v);
      check("readback", v, re[i]);
    end
    for (int i = 0; i < 10; i++)
      wr(ra[i], 8'h00);
    @(posedge core_clk);
    ce <= 1'b0;
    wr(8'h11, 8'h55);
    @(posedge core_clk);
    ce <= 1'b1;
    rd(8'h11, v);
    check("gated write", v, 8'h00);
    $display("registers done");
  endtask

  task automatic test_inject();
    wr(8'h11, 8'h0a);
    wr(8'h10, 8'h05);
    check("inject event", {4'h0, channel_event}, 8'h0f);
    check("inject data", {4'h0, channel_data}, 8'h0a);
    wr(8'h10, 8'h00);
    check("value only event", {4'h0, channel_event}, 8'h0a);
    @(posedge core_clk);
    #1;
    check("inject width", {4'h0, channel_event}, 8'h00);
    wr(8'h11, 8'h00);
    wr(8'h10, 8'h00);
    check("inject none", {4'h0, channel_event}, 8'h00);
    $display("injection done");
  endtask

  task automatic test_filter();
    wr(8'h01, 8'h5b);
    wr(8'h09, 8'h03);
    wr(8'h03, 8'h5b);
    repeat (8) @(posedge core_clk);
    #1;
    check("pin idle", {7'h0, channel_event[1]}, 8'h00);
    event_peripheral_model_inst.set_pin(11, 1'b1);
    repeat (4) @(posedge core_clk);
    #1;
    check("filter early", {7'h0, channel_event[1]}, 8'h00);
    check("pin on ch3", {7'h0, channel_event[3]}, 8'h01);
    @(posedge core_clk);
    #1;
    check("filter pass", {7'h0, channel_event[1]}, 8'h01);
    event_peripheral_model_inst.set_pin(11, 1'b0);
    event_peripheral_model_inst.set_pin(11, 1'b1);
    count(8, 1, c);
    check("glitch blocked", 8'(c), 8'd8);
    event_peripheral_model_inst.set_pin(11, 1'b0);
    $display("filter done");
  endtask

  task automatic test_presc();
    wr(8'h02, 8'h80);
    repeat (4) @(posedge core_clk);
    count(16, 2, c);
    check("divide by 1", 8'(c), 8'd16);
    wr(8'h03, 8'h81);
    repeat (4) @(posedge core_clk);
    count(16, 3, c);
    check("divide by 2", 8'(c), 8'd8);
    wr(8'h03, 8'h84);
    repeat (4) @(posedge core_clk);
    count(32, 3, c);
    check("divide by 16", 8'(c), 8'd2);
    wr(8'h03, 8'h00);
    $display("prescaler done");
  endtask

  task automatic test_timers();
    event_peripheral_model_inst.set_timers(5'h1f);
    for (int i = 0; i < 19; i++)
    begin
      wr(8'h02, tc[i]);
      repeat (4) @(posedge core_clk);
      #1;
      check("timer source", {7'h0, channel_event[2]}, {7'h0, te[i]});
    end
    wr(8'h01, 8'h97);
    repeat (8) @(posedge core_clk);
    #1;
    check("reserved source", {7'h0, channel_event[1]}, 8'h00);
    event_peripheral_model_inst.set_timers(5'h00);
    $display("timers done");
  endtask

  task automatic test_quad();
    wr(8'h09, 8'h00);
    wr(8'h01, 8'h52);
    wr(8'h00, 8'h50);
    wr(8'h08, 8'h08);
    wr(8'h03, 8'h52);
    wr(8'h02, 8'h50);
    wr(8'h0a, 8'h08);
    repeat (6) @(posedge core_clk);
    event_peripheral_model_inst.set_pin(1, 1'b1);
    count(8, 4, c);
    check("forward step", 8'(c), 8'd1);
    event_peripheral_model_inst.set_pin(1, 1'b0);
    count(8, 6, c);
    check("reverse step", 8'(c), 8'd1);
    event_peripheral_model_inst.set_pin(1, 1'b1);
    count(8, 5, c);
    check("forward step ch2", 8'(c), 8'd1);
    event_peripheral_model_inst.set_pin(0, 1'b1);
    count(8, 4, c);
    check("forward 01 to 11", 8'(c), 8'd1);
    wr(8'h08, 8'h78);
    event_peripheral_model_inst.set_pin(2, 1'b1);
    count(10, 8, c);
    check("index match", {7'h0, c > 0}, 8'h01);
    wr(8'h08, 8'h18);
    count(8, 8, c);
    check("index state 00", 8'(c), 8'd0);
    wr(8'h08, 8'h58);
    count(8, 8, c);
    check("index state 10", 8'(c), 8'd0);
    wr(8'h08, 8'h68);
    count(8, 8, c);
    check("index disabled", 8'(c), 8'd0);
    wr(8'h08, 8'h00);
    event_peripheral_model_inst.set_pin(0, 1'b0);
    count(8, 6, c);
    check("decode off", 8'(c), 8'd0);
    wr(8'h0a, 8'h38);
    count(8, 9, c);
    check("index match ch2", {7'h0, c > 0}, 8'h01);
    event_peripheral_model_inst.set_pin(1, 1'b0);
    count(8, 7, c);
    check("reverse step ch2", 8'(c), 8'd1);
    $display("quadrature done");
  endtask

  // ---------------------------------------------------------------
  // main sequence and watchdog
  // ---------------------------------------------------------------
  initial
  begin
    repeat (16) @(posedge core_clk);
    rst <= 1'b0;
    test_regs();
    test_inject();
    test_filter();
    test_presc();
    test_timers();
    test_quad();
    conclude();
  end

  initial
  begin
    #40000;
    fail_count++;
    conclude();
  end
endmodule
